// ---- rtl/asp_pkg.sv ----
// Purpose: Constants and types for the serial readout port of a 10-bit sampling converter.
// Assumes: One 50 MHz clock; chip select, serial clock and frame sync already synchronous.
// Notes:   Host-controller mode only; the frame-sync driven mode is only detected.
//
// How it works
// - Serial clock edges after select start conversion
// - Sample from first rise to sixth zero
// - Six nulls, then result bits on rises
// - Decide on rise, output one bit later
// - Sixteen clocks per frame, gap under 100us
// - Powerdown at 16th fall, wake on 17th
// - Frame sync sampled twice; both high selects host
// - Select rising early aborts the cycle
// - Select high tristates and powers down
// - Frame is six zeros then ten bits
// - Result is ten bits wide
package asp_pkg;

  // Frame layout
  localparam int unsigned ASP_RES_W       = 10;
  localparam int unsigned ASP_NULL_BITS   = 6;
  localparam int unsigned ASP_FRAME_BITS  = 16;
  localparam int unsigned ASP_CNT_W       = 5;
  localparam logic [4:0]  ASP_CNT_RST     = 5'h00;
  localparam logic [4:0]  ASP_SLOT_FIRST  = 5'h01;
  localparam logic [4:0]  ASP_SLOT_NULL   = 5'h06;
  localparam logic [4:0]  ASP_SLOT_LAST   = 5'h10;
  localparam logic [4:0]  ASP_SLOT_DLAST  = 5'h0F;

  // Two-entry decision buffer
  localparam int unsigned ASP_BUF_W       = 1;
  localparam int unsigned ASP_BUF_DEPTH   = 2;
  localparam logic [1:0]  ASP_BUF_CNT_RST = 2'h0;

  // Pause allowed between two clock groups
  localparam int unsigned ASP_CLK_MHZ     = 50;
  localparam int unsigned ASP_GAP_US      = 100;
  localparam int unsigned ASP_GAP_CYC     = ASP_GAP_US * ASP_CLK_MHZ;
  localparam int unsigned ASP_GAP_W       = 16;
  localparam logic [15:0] ASP_GAP_RST     = 16'h0000;

  // Port state
  typedef enum logic [2:0] {
    ASP_OFF   = 3'b000,
    ASP_LATCH = 3'b001,
    ASP_RUN   = 3'b010,
    ASP_PWDN  = 3'b011,
    ASP_FSYNC = 3'b100
  } asp_state_e;

endpackage

// ---- rtl/asp_port.sv ----
// Purpose: Serial readout port in host-controller mode with a two-entry decision buffer.
// Assumes: Pins sampled on clk_i; the converter core answers each decide pulse with one bit.
// Notes:   The serial data pin is split into data and output enable.
//          Outputs other than the handshake ones and the state decodes sdo_oe_o and powerdown_o come straight from flip-flops.
//          Only the frame-sync level around the select edge decides the mode.
`timescale 1ns/10ps

module asp_port #(
  parameter int unsigned GAP_CYCLES = asp_pkg::ASP_GAP_CYC
) (
  input  wire logic                             clk_i,
  input  wire logic                             sys_rst_i,
  input  wire logic                             cs_n_i,
  input  wire logic                             sclk_i,
  input  wire logic                             frame_sync_in_i,
  output logic                                  sdo_o,
  output logic                                  sdo_oe_o,
  output logic                                  sample_o,
  output logic                                  decide_o,
  output logic                                  sar_clear_o,
  output logic                                  powerdown_o,
  output logic                                  host_mode_o,
  output logic                                  gap_err_o,
  input  wire logic                             dec_valid_i,
  input  wire logic [asp_pkg::ASP_BUF_W-1:0]    dec_bit_i,
  output logic                                  dec_ready_o
);
  import asp_pkg::*;

  // Frame walk, one serial clock rise per slot:
  //   select fall     -> latch state, driver on, first mode sample taken
  //   next cycle      -> second mode sample, run state when both are high
  //   rise 1          -> conversion start pulse, track window opens, zero out
  //   rises 2 to 5    -> further leading zeros while the input is tracked
  //   rise 6          -> sixth zero, track window closes, first decision asked
  //   rises 7 to 15   -> one result bit out and the next decision asked
  //   rise 16         -> least significant bit out, no decision left
  //   fall 16         -> auto powerdown, driver stays on while selected
  //   rise 17         -> wakes the port and counts as rise 1 of a new frame
  //   select rise     -> counters, buffer and data flushed, driver off, port powered down
  // Decisions are buffered two deep so a core that answers late still
  // lines up with the slot that shifts the bit out; an empty buffer at a
  // data slot sends a zero rather than stalling the serial clock, which
  // the master owns and cannot be held.
  // The pause watch only runs inside a frame, timing each wait between serial clock rises,
  // so an idle select or a parked powerdown never raises the flag.
  // Core side: decide_o asks for one bit, the core answers with valid and
  // a bit, and dec_ready_o drops while the buffer is full or deselected.
  // Pushes that arrive while deselected are dropped with the flush.
  // A select rise at any point is an abort: counters, buffer and track window
  // return to rest, so a truncated read leaves nothing behind for the next one.

  // Registered state and pointers, plus the combinational next state
  asp_state_e           state;
  asp_state_e           next_state;
  logic                 cs_prev;
  logic                 sclk_prev;
  logic                 fs_first;
  logic [ASP_CNT_W-1:0] slot;
  logic [ASP_GAP_W-1:0] gap_cnt;
  logic [ASP_BUF_W-1:0] buf_mem [ASP_BUF_DEPTH];
  logic                 buf_wp;
  logic                 buf_rp;
  logic [1:0]           buf_cnt;

  // Decoded control, all driven by continuous assignments
  logic                 cs_fall;
  logic                 sclk_rise;
  logic                 sclk_fall;
  logic                 in_run;
  logic                 first_edge;
  logic                 run_rise;
  logic                 next_is_dat;
  logic                 decide_now;
  logic                 frame_end;
  logic                 abort;
  logic                 buf_full;
  logic                 buf_empty;
  logic                 buf_push;
  logic                 buf_pop;
  logic [ASP_BUF_W-1:0] buf_head;
  logic                 gap_hit;
  logic                 next_sdo;

  // Edge decode of the synchronous pins
  assign cs_fall   = cs_prev & ~cs_n_i;
  assign sclk_rise = sclk_i & ~sclk_prev;
  assign sclk_fall = ~sclk_i & sclk_prev;

  // Frame position decode
  assign in_run      = (state == ASP_RUN);
  assign first_edge  = sclk_rise & ((in_run & (slot == ASP_CNT_RST)) | (state == ASP_PWDN));
  assign run_rise    = sclk_rise & in_run & (slot != ASP_CNT_RST);
  assign next_is_dat = run_rise & (slot >= ASP_SLOT_NULL) & (slot < ASP_SLOT_LAST);
  assign decide_now  = run_rise & (slot >= ASP_SLOT_FIRST) & (slot < ASP_SLOT_LAST)
                     & (slot + 5'h01 >= ASP_SLOT_NULL) & (slot + 5'h01 <= ASP_SLOT_DLAST);
  assign frame_end   = sclk_fall & in_run & (slot == ASP_SLOT_LAST);
  assign abort       = cs_n_i;

  // Buffer handshake
  assign buf_full  = (buf_cnt == 2'(ASP_BUF_DEPTH));
  assign buf_empty = (buf_cnt == ASP_BUF_CNT_RST);
  assign buf_push  = dec_valid_i & ~buf_full & ~abort;
  assign buf_pop   = next_is_dat & ~buf_empty;
  assign buf_head  = buf_mem[buf_rp];

  // Bit for the next data slot; an empty buffer sends a zero
  assign next_sdo  = buf_empty ? 1'b0 : buf_head[0];

  assign dec_ready_o = ~buf_full & ~abort;

  // Pin and status outputs from state, decide pulse from the edge decode
  assign sdo_oe_o    = (state == ASP_LATCH) | in_run | (state == ASP_PWDN);
  assign powerdown_o = ~in_run;
  assign decide_o    = decide_now;

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ASP_OFF: begin
        if (cs_fall) begin
          next_state = ASP_LATCH;
        end
      end
      ASP_LATCH: begin
        if (fs_first & frame_sync_in_i) begin
          next_state = ASP_RUN;
        end else begin
          next_state = ASP_FSYNC;
        end
      end
      ASP_RUN: begin
        if (frame_end) begin
          next_state = ASP_PWDN;
        end
      end
      ASP_PWDN: begin
        if (sclk_rise) begin
          next_state = ASP_RUN;
        end
      end
      ASP_FSYNC: begin
        // Other mode is not built: park with the driver off until select rises
        next_state = ASP_FSYNC;
      end
      default: begin
        next_state = ASP_OFF;
      end
    endcase
    if (abort) begin
      next_state = ASP_OFF;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= ASP_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Pin history for edge detection; idle levels so no false edge after reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cs_prev   <= 1'b1;
      sclk_prev <= 1'b0;
    end else begin
      cs_prev   <= cs_n_i;
      sclk_prev <= sclk_i;
    end
  end

  // First mode sample at the select edge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fs_first <= 1'b0;
    end else if (cs_fall) begin
      fs_first <= frame_sync_in_i;
    end
  end

  // Second sample one cycle later; both must read high for host mode
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      host_mode_o <= 1'b0;
    end else if (cs_fall) begin
      host_mode_o <= 1'b0;
    end else if (state == ASP_LATCH) begin
      host_mode_o <= fs_first & frame_sync_in_i;
    end
  end

  // Slot counter, one step per serial clock rise
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || abort) begin
      slot <= ASP_CNT_RST;
    end else if (first_edge) begin
      slot <= ASP_SLOT_FIRST;
    end else if (run_rise && slot < ASP_SLOT_LAST) begin
      slot <= slot + 5'h01;
    end
  end

  // Conversion start pulse to the core
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sar_clear_o <= 1'b0;
    end else begin
      sar_clear_o <= first_edge;
    end
  end

  // Track window: first rise up to the rise sending the sixth zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || abort) begin
      sample_o <= 1'b0;
    end else if (first_edge) begin
      sample_o <= 1'b1;
    end else if (run_rise && slot + 5'h01 == ASP_SLOT_NULL) begin
      sample_o <= 1'b0;
    end
  end

  // Serial data: zeros in null slots, buffered decisions afterwards
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || abort) begin
      sdo_o <= 1'b0;
    end else if (first_edge) begin
      sdo_o <= 1'b0;
    end else if (next_is_dat) begin
      sdo_o <= next_sdo;
    end else if (run_rise) begin
      sdo_o <= 1'b0;
    end
  end

  // Buffer storage, one generate slot per entry
  genvar gi;
  generate
    for (gi = 0; gi < ASP_BUF_DEPTH; gi++) begin : g_buf
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          buf_mem[gi] <= '0;
        end else if (buf_push && buf_wp == 1'(gi)) begin
          buf_mem[gi] <= dec_bit_i;
        end
      end
    end
  endgenerate

  // Write pointer, flushed when a cycle ends early or a frame starts
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || abort || first_edge) begin
      buf_wp <= 1'b0;
    end else begin
      buf_wp <= buf_wp ^ buf_push;
    end
  end

  // Read pointer, flushed alongside the write pointer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || abort || first_edge) begin
      buf_rp <= 1'b0;
    end else begin
      buf_rp <= buf_rp ^ buf_pop;
    end
  end

  // Fill count; a push and a pop in one cycle leave it unchanged
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || abort || first_edge) begin
      buf_cnt <= ASP_BUF_CNT_RST;
    end else begin
      buf_cnt <= buf_cnt + 2'(buf_push) - 2'(buf_pop);
    end
  end

  // Pause limit reached
  assign gap_hit = (gap_cnt >= ASP_GAP_W'(GAP_CYCLES));

  // Pause counter, running only while a frame waits for its next rise
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || cs_fall) begin
      gap_cnt <= ASP_GAP_RST;
    end else if (!in_run || sclk_rise || slot == ASP_CNT_RST) begin
      gap_cnt <= ASP_GAP_RST;
    end else if (!gap_hit) begin
      gap_cnt <= gap_cnt + 16'h0001;
    end
  end

  // Sticky pause flag, cleared only by the next select fall
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || cs_fall) begin
      gap_err_o <= 1'b0;
    end else if (in_run && gap_hit) begin
      gap_err_o <= 1'b1;
    end
  end

endmodule // asp_port

// ---- tb/asp_port_sva.sv ----
// Purpose: Port checks for the serial readout port
// Assumes: One clock, sync reset
// Notes:   Bound to asp_port
`timescale 1ns/10ps
module asp_port_sva (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic frame_sync_in_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic sample_o,
  input wire logic decide_o,
  input wire logic sar_clear_o,
  input wire logic powerdown_o,
  input wire logic host_mode_o,
  input wire logic gap_err_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Select fall held low one more cycle
  sequence s_sel;
    $fell(cs_n_i) ##1 !cs_n_i;
  endsequence
  a_oe_on: assert property ($fell(cs_n_i) && frame_sync_in_i |=> sdo_oe_o)
    else $error("driver off after select fall");
  a_oe_off: assert property (cs_n_i |=> !sdo_oe_o)
    else $error("driver on while deselected");
  a_mode_both: assert property (s_sel |=> host_mode_o ==
    ($past(frame_sync_in_i, 2) && $past(frame_sync_in_i)))
    else $error("mode does not follow both samples");
  a_sample_clr: assert property ($rose(sample_o) |-> sar_clear_o)
    else $error("sampling began without start");
  a_sdo_null: assert property (sample_o |-> !sdo_o)
    else $error("data bit during sampling");
  a_sdo_step: assert property ($changed(sdo_o) && !cs_n_i && !$past(cs_n_i)
    |-> $past(sclk_i) && !$past(sclk_i, 3))
    else $error("data moved without clock rise");
  a_gap_clr: assert property ($fell(cs_n_i) |-> ##2 !gap_err_o)
    else $error("pause flag kept over select fall");
  a_decide_run: assert property (decide_o |-> !cs_n_i && !powerdown_o)
    else $error("decision outside running frame");
endmodule // asp_port_sva
bind asp_port asp_port_sva u_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i),
  .sclk_i(sclk_i), .frame_sync_in_i(frame_sync_in_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
  .sample_o(sample_o), .decide_o(decide_o), .sar_clear_o(sar_clear_o),
  .powerdown_o(powerdown_o), .host_mode_o(host_mode_o), .gap_err_o(gap_err_o));

// ---- tb/asp_spi_master.sv ----
// Purpose: Host controller model driving select and serial clock
// Assumes: Changes land at falling clk edges
// Notes:   Four clk cycles per serial clock half period
`timescale 1ns/10ps
module asp_spi_master (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      cs_n_o,
  output logic      sclk_o
);
  logic last;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    last   = 1'b0;
  end
  // Clocks n bits, pausing after the eighth, taking each bit before the fall
  task automatic xfer(input int n, input int pause, output logic [15:0] w);
    w = 16'h0000;
    @(negedge clk_i) cs_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      if (i == 8) repeat (pause) @(negedge clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      last = sdo_oe_i ? sdo_i : ~last;
      w = {w[14:0], last};
      sclk_o = 1'b0;
      repeat (4) @(negedge clk_i);
    end
  endtask
  // Raises select, early or after the last bit
  task automatic done();
    cs_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask
endmodule // asp_spi_master

// ---- tb/asp_port_tb.sv ----
// Purpose: Self-checking bench for the serial readout port
// Assumes: Core stand-in answers decide pulses at once
// Notes:   Pause limit shortened to 20 cycles
`timescale 1ns/10ps
module asp_port_tb;
  import asp_pkg::*;
  logic                 clk, rst, fs, cs_n, sclk, sdo, oe, samp, dec, clr, pd, host, gap, vld, rdy;
  logic [ASP_BUF_W-1:0] dbit;
  logic                 dec_seen;
  logic [9:0]           res;
  logic [15:0]          w;
  int                   didx, n_errors, check_count;
  asp_port #(.GAP_CYCLES(20)) DUT (.clk_i(clk), .sys_rst_i(rst), .cs_n_i(cs_n), .sclk_i(sclk),
    .frame_sync_in_i(fs), .sdo_o(sdo), .sdo_oe_o(oe), .sample_o(samp), .decide_o(dec),
    .sar_clear_o(clr), .powerdown_o(pd), .host_mode_o(host), .gap_err_o(gap),
    .dec_valid_i(vld), .dec_bit_i(dbit), .dec_ready_o(rdy));
  asp_spi_master MST (.clk_i(clk), .sdo_i(sdo), .sdo_oe_i(oe), .cs_n_o(cs_n), .sclk_o(sclk));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Decide pulse lasts only until the edge that sees it, so catch it there
  always @(posedge clk) dec_seen <= dec;
  // Core stand-in: each decide pulse gets the next result bit, MSB first
  always @(negedge clk) begin
    if (clr) didx = 9;
    vld = dec_seen;
    if (dec_seen) dbit = res[didx];
    if (dec_seen) didx--;
  end
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Two back-to-back frames, the second woken by the 17th rise
  task automatic t_frames();
    res = 10'h2C5;
    MST.xfer(16, 0, w);
    check("word", {6'h00, 10'h2C5}, w);
    check("pwdn", 16'h0001, {15'h0, pd});
    check("host", 16'h0001, {15'h0, host});
    res = 10'h13A;
    MST.xfer(16, 0, w);
    check("word2", {6'h00, 10'h13A}, w);
    MST.done();
    check("oe", 16'h0000, {15'h0, oe});
    check("rdy", 16'h0000, {15'h0, rdy});
  endtask
  // Frame split in two groups, inside and beyond the pause limit
  task automatic t_split();
    res = 10'h0F3;
    MST.xfer(16, 8, w);
    check("split", {6'h00, 10'h0F3}, w);
    check("gap", 16'h0000, {15'h0, gap});
    MST.done();
    MST.xfer(16, 30, w);
    check("gap", 16'h0001, {15'h0, gap});
    MST.done();
  endtask
  // Fourteen-bit read, then two fresh full frames
  task automatic t_trunc();
    res = 10'h3A6;
    MST.xfer(14, 0, w);
    MST.done();
    check("trunc", {8'h00, 8'hE9}, w);
    check("pwdn", 16'h0001, {15'h0, pd});
    t_frames();
  endtask
  // Frame sync levels at the two mode samples
  task automatic t_mode(input logic a, input logic b);
    @(negedge clk) MST.cs_n_o = 1'b0;
    fs = a;
    @(negedge clk) fs = b;
    repeat (3) @(negedge clk);
    check("host", {15'h0, a & b}, {15'h0, host});
    check("oe", {15'h0, a & b}, {15'h0, oe});
    fs = 1'b1;
    MST.done();
  endtask
  initial begin
    rst = 1'b1;
    fs = 1'b1;
    res = 10'h000;
    didx = 9;
    vld = 1'b0;
    dbit = '0;
    n_errors = 0;
    check_count = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_frames();
    t_split();
    t_trunc();
    for (int k = 0; k < 4; k++) t_mode(k[0], k[1]);
    print_verdict();
  end
  // Hang guard
  initial begin
    #2000000;
    n_errors++;
    print_verdict();
  end
endmodule // asp_port_tb
